// >>> pcrb_pkg.sv
package pcrb_pkg;

  localparam int unsigned ADDR_W = 8;
  localparam int unsigned DATA_W = 8;

  localparam logic [7:0] OFF_PULL_UP_B    = 8'h49;
  localparam logic [7:0] OFF_PULL_DOWN_A  = 8'h4a;
  localparam logic [7:0] OFF_PULL_DOWN_B  = 8'h4b;
  localparam logic [7:0] OFF_DRIVE_A      = 8'h4c;
  localparam logic [7:0] OFF_DRIVE_B      = 8'h4d;

  localparam logic [7:0] RST_PULL_UP_B    = 8'h1f;
  localparam logic [7:0] RST_PULL_DOWN_A  = 8'h00;
  localparam logic [7:0] RST_PULL_DOWN_B  = 8'h00;
  localparam logic [7:0] RST_DRIVE_A      = 8'h00;
  localparam logic [7:0] RST_DRIVE_B      = 8'h00;

  // Field positions of the five control pins in pull-up/pull-down B
  localparam int unsigned POS_ADDR0      = 0;
  localparam int unsigned POS_ADDR1      = 1;
  localparam int unsigned POS_CTRL_DATA  = 2;
  localparam int unsigned POS_CTRL_CLOCK = 3;
  localparam int unsigned POS_BOOT_SEL   = 4;

  // Field positions in pull-down A
  localparam int unsigned POS_PLAYBACK_IN = 0;
  localparam int unsigned POS_CONV_OUT0   = 1;
  localparam int unsigned POS_CONV_OUT1   = 2;
  localparam int unsigned POS_BIT_CLOCK   = 3;
  localparam int unsigned POS_FRAME_CLOCK = 4;
  localparam int unsigned POS_MIC_PAIR_A  = 5;
  localparam int unsigned POS_MIC_PAIR_B  = 6;

  // Field positions in drive A (bit 0 reserved) and drive B
  localparam int unsigned POS_DRV_CONV_OUT0   = 1;
  localparam int unsigned POS_DRV_CONV_OUT1   = 2;
  localparam int unsigned POS_DRV_BIT_CLOCK   = 3;
  localparam int unsigned POS_DRV_FRAME_CLOCK = 4;
  localparam int unsigned POS_DRV_CTRL_DATA   = 2;
  localparam int unsigned POS_DRV_CTRL_CLOCK  = 3;

  typedef struct packed {
    logic boot_select_pullup_off;
    logic ctrl_clock_pullup_off;
    logic ctrl_data_pullup_off;
    logic addr_pin1_pullup_off;
    logic addr_pin0_pullup_off;
  } pcrb_pullup_t;

  typedef struct packed {
    logic mic_pair_b_pulldown_on;
    logic mic_pair_a_pulldown_on;
    logic frame_clock_pulldown_on;
    logic bit_clock_pulldown_on;
    logic conv_out1_pulldown_on;
    logic conv_out0_pulldown_on;
    logic playback_in_pulldown_on;
    logic boot_select_pulldown_on;
    logic ctrl_clock_pulldown_on;
    logic ctrl_data_pulldown_on;
    logic addr_pin1_pulldown_on;
    logic addr_pin0_pulldown_on;
  } pcrb_pulldown_t;

  typedef struct packed {
    logic frame_clock_drive_high;
    logic bit_clock_drive_high;
    logic conv_out1_drive_high;
    logic conv_out0_drive_high;
    logic ctrl_clock_drive_high;
    logic ctrl_data_drive_high;
  } pcrb_drive_t;

endpackage

// >>> pcrb_pad_config.sv
`timescale 1ns/1ps
`default_nettype none
module pcrb_pad_config (
  // Clock and reset
  input  wire logic                       clk_i,
  input  wire logic                       rst_i,
  // Register access from the control port
  input  wire logic                       reg_wr_i,
  input  wire logic [pcrb_pkg::ADDR_W-1:0] reg_addr_i,
  input  wire logic [pcrb_pkg::DATA_W-1:0] reg_wdata_i,
  output logic      [pcrb_pkg::DATA_W-1:0] reg_rdata_o,
  output logic                            reg_hit_o,
  // Pad controls
  output pcrb_pkg::pcrb_pullup_t          pullup_o,
  output pcrb_pkg::pcrb_pulldown_t        pulldown_o,
  output pcrb_pkg::pcrb_drive_t           drive_o
);

  logic [7:0] pu_b_q, pu_b_d;
  logic [7:0] pd_a_q, pd_a_d;
  logic [7:0] pd_b_q, pd_b_d;
  logic [7:0] dr_a_q, dr_a_d;
  logic [7:0] dr_b_q, dr_b_d;

  // Whole bytes are stored, reserved bits included
  always_comb begin
    pu_b_d = pu_b_q;
    pd_a_d = pd_a_q;
    pd_b_d = pd_b_q;
    dr_a_d = dr_a_q;
    dr_b_d = dr_b_q;
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        pcrb_pkg::OFF_PULL_UP_B:   pu_b_d = reg_wdata_i;
        pcrb_pkg::OFF_PULL_DOWN_A: pd_a_d = reg_wdata_i;
        pcrb_pkg::OFF_PULL_DOWN_B: pd_b_d = reg_wdata_i;
        pcrb_pkg::OFF_DRIVE_A:     dr_a_d = reg_wdata_i;
        pcrb_pkg::OFF_DRIVE_B:     dr_b_d = reg_wdata_i;
        default: ;
      endcase
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      pu_b_q <= pcrb_pkg::RST_PULL_UP_B;
      pd_a_q <= pcrb_pkg::RST_PULL_DOWN_A;
      pd_b_q <= pcrb_pkg::RST_PULL_DOWN_B;
      dr_a_q <= pcrb_pkg::RST_DRIVE_A;
      dr_b_q <= pcrb_pkg::RST_DRIVE_B;
    end else begin
      pu_b_q <= pu_b_d;
      pd_a_q <= pd_a_d;
      pd_b_q <= pd_b_d;
      dr_a_q <= dr_a_d;
      dr_b_q <= dr_b_d;
    end
  end

  // Read path; unmapped offsets read zero with hit low
  always_comb begin
    reg_rdata_o = '0;
    reg_hit_o   = 1'b1;
    unique case (reg_addr_i)
      pcrb_pkg::OFF_PULL_UP_B:   reg_rdata_o = pu_b_q;
      pcrb_pkg::OFF_PULL_DOWN_A: reg_rdata_o = pd_a_q;
      pcrb_pkg::OFF_PULL_DOWN_B: reg_rdata_o = pd_b_q;
      pcrb_pkg::OFF_DRIVE_A:     reg_rdata_o = dr_a_q;
      pcrb_pkg::OFF_DRIVE_B:     reg_rdata_o = dr_b_q;
      default:                   reg_hit_o   = 1'b0;
    endcase
  end

  // Pad controls take only defined bits; reserved bits go nowhere
  always_comb begin
    // Bit set means pull-up off
    pullup_o.boot_select_pullup_off = pu_b_q[pcrb_pkg::POS_BOOT_SEL];
    pullup_o.ctrl_clock_pullup_off  = pu_b_q[pcrb_pkg::POS_CTRL_CLOCK];
    pullup_o.ctrl_data_pullup_off   = pu_b_q[pcrb_pkg::POS_CTRL_DATA];
    pullup_o.addr_pin1_pullup_off   = pu_b_q[pcrb_pkg::POS_ADDR1];
    pullup_o.addr_pin0_pullup_off   = pu_b_q[pcrb_pkg::POS_ADDR0];
    // Bit set means pull-down on
    pulldown_o.mic_pair_b_pulldown_on  = pd_a_q[pcrb_pkg::POS_MIC_PAIR_B];
    pulldown_o.mic_pair_a_pulldown_on  = pd_a_q[pcrb_pkg::POS_MIC_PAIR_A];
    pulldown_o.frame_clock_pulldown_on = pd_a_q[pcrb_pkg::POS_FRAME_CLOCK];
    pulldown_o.bit_clock_pulldown_on   = pd_a_q[pcrb_pkg::POS_BIT_CLOCK];
    pulldown_o.conv_out1_pulldown_on   = pd_a_q[pcrb_pkg::POS_CONV_OUT1];
    pulldown_o.conv_out0_pulldown_on   = pd_a_q[pcrb_pkg::POS_CONV_OUT0];
    pulldown_o.playback_in_pulldown_on = pd_a_q[pcrb_pkg::POS_PLAYBACK_IN];
    pulldown_o.boot_select_pulldown_on = pd_b_q[pcrb_pkg::POS_BOOT_SEL];
    pulldown_o.ctrl_clock_pulldown_on  = pd_b_q[pcrb_pkg::POS_CTRL_CLOCK];
    pulldown_o.ctrl_data_pulldown_on   = pd_b_q[pcrb_pkg::POS_CTRL_DATA];
    pulldown_o.addr_pin1_pulldown_on   = pd_b_q[pcrb_pkg::POS_ADDR1];
    pulldown_o.addr_pin0_pulldown_on   = pd_b_q[pcrb_pkg::POS_ADDR0];
    // Bit set means high drive
    drive_o.frame_clock_drive_high = dr_a_q[pcrb_pkg::POS_DRV_FRAME_CLOCK];
    drive_o.bit_clock_drive_high   = dr_a_q[pcrb_pkg::POS_DRV_BIT_CLOCK];
    drive_o.conv_out1_drive_high   = dr_a_q[pcrb_pkg::POS_DRV_CONV_OUT1];
    drive_o.conv_out0_drive_high   = dr_a_q[pcrb_pkg::POS_DRV_CONV_OUT0];
    drive_o.ctrl_clock_drive_high  = dr_b_q[pcrb_pkg::POS_DRV_CTRL_CLOCK];
    drive_o.ctrl_data_drive_high   = dr_b_q[pcrb_pkg::POS_DRV_CTRL_DATA];
  end

  chk_pullup_reset_value: assert property (@(posedge clk_i)
    $past(rst_i) |-> pu_b_q == pcrb_pkg::RST_PULL_UP_B
      && pullup_o == 5'(pcrb_pkg::RST_PULL_UP_B))
    else $error("pull-up register not at reset value after reset");

  chk_pullup_write_polarity: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_UP_B |=>
      pullup_o == $past(reg_wdata_i[4:0]))
    else $error("pull-up bits do not follow written value");

  chk_pd_a_reset_zero: assert property (@(posedge clk_i)
    $past(rst_i) |-> pd_a_q == pcrb_pkg::RST_PULL_DOWN_A)
    else $error("pull-down A not zero after reset");

  chk_pd_b_reset_zero: assert property (@(posedge clk_i)
    $past(rst_i) |-> pd_b_q == pcrb_pkg::RST_PULL_DOWN_B)
    else $error("pull-down B not zero after reset");

  chk_pulldown_write_on: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_A |=>
      pulldown_o[11:5] == $past(reg_wdata_i[6:0]))
    else $error("pull-down A pad bits do not follow write");

  chk_drive_a_fields: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_DRIVE_A |=>
      drive_o[5:2] == $past(reg_wdata_i[4:1]))
    else $error("drive A pad bits do not follow write");

  chk_drive_b_fields: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_DRIVE_B |=>
      drive_o[1:0] == $past(reg_wdata_i[3:2]))
    else $error("drive B pad bits do not follow write");

  chk_reserved_no_effect: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_DRIVE_B
      && reg_wdata_i[3:2] == dr_b_q[3:2]
      |=> $stable(drive_o))
    else $error("reserved drive bits changed pad controls");

  chk_pulldown_reset_off: assert property (@(posedge clk_i)
    $past(rst_i) |-> pulldown_o == '0)
    else $error("a pull-down is on after reset");

  chk_drive_a_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> dr_a_q == pcrb_pkg::RST_DRIVE_A)
    else $error("drive A not zero after reset");

  chk_drive_b_reset: assert property (@(posedge clk_i)
    $past(rst_i) |-> dr_b_q == pcrb_pkg::RST_DRIVE_B)
    else $error("drive B not zero after reset");

  chk_pd_b_fields: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_B |=>
      pulldown_o[4:0] == $past(reg_wdata_i[4:0]))
    else $error("pull-down B pad bits do not follow write");

  chk_pullup_stored: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_UP_B |=>
      pu_b_q == $past(reg_wdata_i))
    else $error("pull-up register did not store the written byte");

  chk_pd_a_stored: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_A |=>
      pd_a_q == $past(reg_wdata_i))
    else $error("pull-down A did not store the written byte");

  chk_pd_b_stored: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_B |=>
      pd_b_q == $past(reg_wdata_i))
    else $error("pull-down B did not store the written byte");

  chk_drive_a_stored: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_DRIVE_A |=>
      dr_a_q == $past(reg_wdata_i))
    else $error("drive A did not store the written byte");

  chk_drive_b_stored: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_DRIVE_B |=>
      dr_b_q == $past(reg_wdata_i))
    else $error("drive B did not store the written byte");

  chk_pullup_holds: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !(reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_UP_B)
      |=> $stable(pu_b_q))
    else $error("pull-up register changed without a write");

  chk_pulldown_holds: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !(reg_wr_i && (reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_A
                   || reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_B))
      |=> $stable(pulldown_o))
    else $error("pull-down controls changed without a write");

  chk_drive_holds: assert property (@(posedge clk_i)
    disable iff (rst_i)
    !(reg_wr_i && (reg_addr_i == pcrb_pkg::OFF_DRIVE_A
                   || reg_addr_i == pcrb_pkg::OFF_DRIVE_B))
      |=> $stable(drive_o))
    else $error("drive controls changed without a write");

  chk_pullup_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_PULL_UP_B
      && reg_wdata_i[4:0] == pu_b_q[4:0]
      |=> $stable(pullup_o))
    else $error("reserved pull-up bits changed pad controls");

  chk_drive_a_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i && reg_addr_i == pcrb_pkg::OFF_DRIVE_A
      && reg_wdata_i[4:1] == dr_a_q[4:1]
      |=> $stable(drive_o))
    else $error("reserved drive A bits changed pad controls");

  chk_pd_reserved: assert property (@(posedge clk_i)
    disable iff (rst_i)
    reg_wr_i
      && ((reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_A
           && reg_wdata_i[6:0] == pd_a_q[6:0])
          || (reg_addr_i == pcrb_pkg::OFF_PULL_DOWN_B
              && reg_wdata_i[4:0] == pd_b_q[4:0]))
      |=> $stable(pulldown_o))
    else $error("reserved pull-down bits changed pad controls");

endmodule
`default_nettype wire

// >>> tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                     clk_i       = 1'b0;
  logic                     rst_i       = 1'b1;
  logic                     reg_wr_i    = 1'b0;
  logic [7:0]               reg_addr_i  = 8'h00;
  logic [7:0]               reg_wdata_i = 8'h00;
  logic [7:0]               reg_rdata_o;
  logic                     reg_hit_o;
  pcrb_pkg::pcrb_pullup_t   pullup_o;
  pcrb_pkg::pcrb_pulldown_t pulldown_o;
  pcrb_pkg::pcrb_drive_t    drive_o;
  logic [7:0]               mdl [5];
  logic [7:0]               pats [6] = '{8'hff, 8'h00, 8'ha5, 8'h5a,
                                         8'he1, 8'h80};
  logic [7:0]               holes [4] = '{8'h48, 8'h4e, 8'h00, 8'hff};
  int                       bad_count = 0;
  int                       checks = 0;

  always #20 clk_i = ~clk_i;

  pcrb_pad_config pcrb_pad_config_i (
    .clk_i(clk_i), .rst_i(rst_i), .reg_wr_i(reg_wr_i),
    .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .reg_hit_o(reg_hit_o),
    .pullup_o(pullup_o), .pulldown_o(pulldown_o), .drive_o(drive_o));

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  // Write strobe stays high so calls may run back to back
  task automatic put(input logic [7:0] a, input logic [7:0] d);
    reg_wr_i = 1'b1;
    reg_addr_i = a;
    reg_wdata_i = d;
    @(posedge clk_i);
    #1;
  endtask

  task automatic get(input logic [7:0] a, input logic [7:0] exp,
                     input logic hit);
    reg_wr_i = 1'b0;
    reg_addr_i = a;
    #2;
    check("read data", {8'h00, reg_rdata_o}, {8'h00, exp});
    check("hit flag", {15'h0, reg_hit_o}, {15'h0, hit});
    @(posedge clk_i);
    #1;
  endtask

  task automatic check_all();
    for (int i = 0; i < 5; i++) begin
      get(8'h49 + 8'(i), mdl[i], 1'b1);
    end
    check("pullups", {11'h0, pullup_o}, {11'h0, mdl[0][4:0]});
    check("pulldowns", {4'h0, pulldown_o},
          {4'h0, mdl[1][6:0], mdl[2][4:0]});
    check("drives", {10'h0, drive_o},
          {10'h0, mdl[3][4:1], mdl[4][3:2]});
  endtask

  initial begin
    repeat (3000) @(posedge clk_i);
    bad_count++;
    $display("BAD watchdog expected end seen hang");
    tally_and_finish();
  end

  initial begin
    mdl = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
    repeat (20) @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    check_all();
    $display("reset values test done");
    // Every register written on consecutive cycles, reserved bits too
    foreach (pats[p]) begin
      for (int i = 0; i < 5; i++) begin
        put(8'h49 + 8'(i), pats[p]);
        mdl[i] = pats[p];
      end
      check_all();
    end
    $display("pattern test done");
    // Unmapped offsets neither store nor alias onto neighbours
    foreach (holes[h]) put(holes[h], 8'h3c);
    foreach (holes[h]) get(holes[h], 8'h00, 1'b0);
    check_all();
    $display("unmapped test done");
    // Second reset in mid-run; a write under reset is ignored
    rst_i = 1'b1;
    put(8'h4a, 8'h7f);
    reg_wr_i = 1'b0;
    @(posedge clk_i);
    #1;
    rst_i = 1'b0;
    mdl = '{8'h1f, 8'h00, 8'h00, 8'h00, 8'h00};
    check_all();
    $display("mid-run reset test done");
    // Reserved-only writes are stored but leave the pads alone
    put(8'h4a, 8'h80);
    put(8'h4b, 8'he0);
    mdl[1] = 8'h80;
    mdl[2] = 8'he0;
    check_all();
    $display("reserved bits test done");
    tally_and_finish();
  end
endmodule
`default_nettype wire
